//--- rtl/qsf_defs.svh
// constants of the quad serial flash sequencer
// assumes a 200 MHz core clock; included by the sequencer and the bench
`ifndef QSF_DEFS_SVH
`define QSF_DEFS_SVH

`define QSF_CMD_BITS      6'd8
`define QSF_ADDR_BITS     6'd24
`define QSF_CX_EXT        (6'd7 + `QSF_ADDR_BITS)
`define QSF_CX_QUAD       (6'd1 + `QSF_ADDR_BITS / 6'd4)
`define QSF_RW_LAST_EXT   6'd23
`define QSF_RW_LAST_QUAD  6'd5
`define QSF_STEP_EXT      6'd1
`define QSF_STEP_QUAD     6'd4
`define QSF_BYTE_LAST_EXT 4'd7
`define QSF_BYTE_LAST_Q   4'd1
`define QSF_DUMMY_EXT     4'd8
`define QSF_DUMMY_QUAD    4'd10
`define QSF_LOCK_RD_OP    8'he8
`define QSF_LOCK_WR_OP    8'he5
`define QSF_OE_IDLE       4'hc
`define QSF_OE_EXT        4'hd
`define QSF_OE_QUAD_OUT   4'hf
`define QSF_OE_QUAD_IN    4'h0
`define QSF_EXT_HI_LANES  3'h6
`define QSF_CLK_PERIOD_NS 5
`define QSF_CS_HIGH_NS    50
`define QSF_CS_HIGH_CYC   ((`QSF_CS_HIGH_NS + `QSF_CLK_PERIOD_NS - 1) / `QSF_CLK_PERIOD_NS)

`endif

//--- rtl/qsf_pkg.sv
// types shared by the quad serial flash sequencer
// assumes nothing beyond a SystemVerilog compiler
package qsf_pkg;

  typedef enum logic [5:0] {
    qsf_st_idle  = 6'h01,
    qsf_st_shift = 6'h02,
    qsf_st_dummy = 6'h04,
    qsf_st_wdata = 6'h08,
    qsf_st_rdata = 6'h10,
    qsf_st_gap   = 6'h20
  } qsf_state_t;

  typedef enum logic [1:0] {
    qsf_reg_rd    = 2'h0,
    qsf_reg_wr    = 2'h1,
    qsf_fast_rd   = 2'h2,
    qsf_page_prog = 2'h3
  } qsf_kind_t;

endpackage

//--- rtl/qsf_fifo.sv
// fifo of received flash bytes, registered read port
// assumes one clock, synchronous active high reset, DEPTH a power of two
`timescale 1ns/10ps
module qsf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } qsf_fifo_st_t;

  qsf_fifo_st_t st;
  qsf_fifo_st_t next_st;
  logic         push;
  logic         pop;

  always_comb begin
    next_st = st;
    push    = in_valid_in && (st.count != FULL);
    pop     = (st.count != '0) && (!st.out_valid || out_ready_in);
    if (out_ready_in) begin
      next_st.out_valid = 1'b0;
    end
    if (pop) begin
      next_st.out_data  = st.mem[st.rd_ptr];
      next_st.out_valid = 1'b1;
      next_st.rd_ptr    = st.rd_ptr + 1'b1;
    end
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data_in;
      next_st.wr_ptr         = st.wr_ptr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready_out  = (st.count != FULL);
  assign out_valid_out = st.out_valid;
  assign out_data_out  = st.out_data;

  count_bound_a: assert property (@(posedge core_clk_in) disable iff (rst_in) st.count <= FULL)
    else $error("fifo count above depth");
  full_refuse_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (st.count == FULL && !pop) |=> st.count == FULL)
    else $error("fifo accepted while full");
endmodule

//--- rtl/qsf_seq.sv
// quad serial flash sequencer: register and memory commands to a serial NOR flash
// assumes a 200 MHz core clock, flash in spi mode 0, one command at a time
// Contract
// RULE_01 - all register reads except lock read
// RULE_02 - config register bytes arrive low byte first
// RULE_03 - all register writes except lock write
// RULE_04 - register write ends position 23 or 5
// RULE_05 - config register write sends low byte first
// RULE_06 - 24-bit address sent bit 23 first
// RULE_07 - extended command plus address ends at 31
// RULE_08 - quad command plus address ends at 1+24/4
// RULE_09 - fast read: command, address, flash data
// RULE_10 - page program: command, address, device data
// RULE_11 - chip select low whole frame, high between
`timescale 1ns/10ps
`include "qsf_defs.svh"
module qsf_seq #(
  parameter int DIV        = 4,
  parameter int LEN_W      = 9,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  input  wire logic               cmd_valid_in,
  output logic                    cmd_ready_out,
  input  wire qsf_pkg::qsf_kind_t cmd_kind_in,
  input  wire logic               cmd_quad_in,
  input  wire logic [7:0]         cmd_opcode_in,
  input  wire logic [23:0]        cmd_addr_in,
  input  wire logic [LEN_W-1:0]   cmd_len_in,
  input  wire logic [15:0]        cmd_reg_data_in,
  output logic                    cmd_done_out,
  output logic                    cmd_err_out,
  input  wire logic               wr_valid_in,
  output logic                    wr_ready_out,
  input  wire logic [7:0]         wr_data_in,
  output logic                    rd_valid_out,
  input  wire logic               rd_ready_in,
  output logic [7:0]              rd_data_out,
  output logic                    sck_out,
  output logic                    cs_n_out,
  output logic [3:0]              dq_out,
  output logic [3:0]              dq_oe_out,
  input  wire logic [3:0]         dq_in
);
  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam logic [3:0] GAP_LAST = 4'(`QSF_CS_HIGH_CYC - 1);

  typedef struct packed {
    qsf_pkg::qsf_state_t state;
    qsf_pkg::qsf_kind_t  kind;
    logic                quad;
    logic [LEN_W-1:0]    len;
    logic [5:0]          pos;
    logic [5:0]          last;
    logic [3:0]          bitc;
    logic [7:0]          div;
    logic [3:0]          gap;
    logic                sck;
    logic                cs_n;
    logic [3:0]          dq_o;
    logic [3:0]          dq_oe;
    logic [31:0]         sh;
    logic [7:0]          rx;
    logic [7:0]          wbuf;
    logic                wbuf_full;
    logic                wr_rdy;
    logic                cmd_rdy;
    logic                push;
    logic                done;
    logic                err;
    logic [3:0]          sync1;
    logic [3:0]          sync2;
  } qsf_seq_st_t;

  qsf_seq_st_t st;
  qsf_seq_st_t next_st;
  logic        fifo_ready;
  logic        accept;
  logic        lock_cmd;
  logic        tick;
  logic        byte_end;
  logic        need_byte;

  function automatic logic [5:0] step(input logic quad);
    step = quad ? `QSF_STEP_QUAD : `QSF_STEP_EXT;
  endfunction

  function automatic logic [3:0] lanes(input logic [31:0] sh, input logic quad);
    lanes = quad ? sh[31:28] : {`QSF_EXT_HI_LANES, sh[31]};
  endfunction

  function automatic logic [3:0] out_oe(input logic quad);
    out_oe = quad ? `QSF_OE_QUAD_OUT : `QSF_OE_EXT;
  endfunction

  function automatic logic [3:0] in_oe(input logic quad);
    in_oe = quad ? `QSF_OE_QUAD_IN : `QSF_OE_EXT;
  endfunction

  // command phase end position per command kind and lane mode
  function automatic logic [5:0] last_pos(input qsf_pkg::qsf_kind_t kind, input logic quad);
    case (kind)
      qsf_pkg::qsf_reg_wr: last_pos = quad ? `QSF_RW_LAST_QUAD : `QSF_RW_LAST_EXT;
      qsf_pkg::qsf_reg_rd: last_pos = `QSF_CMD_BITS / step(quad) - 6'd1;
      default:             last_pos = quad ? `QSF_CX_QUAD : `QSF_CX_EXT;
    endcase
  endfunction

  always_comb begin
    next_st       = st;
    next_st.sync1 = dq_in;
    next_st.sync2 = st.sync1;
    next_st.push  = 1'b0;
    next_st.done  = 1'b0;
    next_st.err   = 1'b0;
    accept        = cmd_valid_in && st.cmd_rdy;
    lock_cmd      = (cmd_kind_in == qsf_pkg::qsf_reg_rd && cmd_opcode_in == `QSF_LOCK_RD_OP) ||
                    (cmd_kind_in == qsf_pkg::qsf_reg_wr && cmd_opcode_in == `QSF_LOCK_WR_OP);
    tick          = (st.div == DIV_LAST);
    byte_end      = st.bitc == (st.quad ? `QSF_BYTE_LAST_Q : `QSF_BYTE_LAST_EXT);
    need_byte     = (st.state == qsf_pkg::qsf_st_shift && st.pos == st.last &&
                     st.kind == qsf_pkg::qsf_page_prog) ||
                    (st.state == qsf_pkg::qsf_st_wdata && byte_end && st.len != LEN_W'(1));
    if (wr_valid_in && st.wr_rdy) begin
      next_st.wbuf      = wr_data_in;
      next_st.wbuf_full = 1'b1;
      next_st.wr_rdy    = 1'b0;
    end
    case (st.state)
      qsf_pkg::qsf_st_idle: begin
        next_st.div = '0;
        if (accept) begin
          if (lock_cmd) begin
            // RULE_01 lock read refused
            // RULE_03 lock write refused
            next_st.err = 1'b1;
          end else begin
            next_st.state   = qsf_pkg::qsf_st_shift;
            next_st.cmd_rdy = 1'b0;
            next_st.kind    = cmd_kind_in;
            next_st.quad    = cmd_quad_in;
            next_st.len     = (cmd_len_in == '0) ? LEN_W'(1) : cmd_len_in;
            next_st.pos     = '0;
            next_st.bitc    = '0;
            next_st.last    = last_pos(cmd_kind_in, cmd_quad_in);
            // RULE_11 select for whole frame
            next_st.cs_n    = 1'b0;
            case (cmd_kind_in)
              // RULE_05 low byte first
              qsf_pkg::qsf_reg_wr: next_st.sh = {cmd_opcode_in, cmd_reg_data_in[7:0],
                                                 cmd_reg_data_in[15:8], 8'h00};
              qsf_pkg::qsf_reg_rd: next_st.sh = {cmd_opcode_in, 24'h000000};
              // RULE_06 address msb first
              default:             next_st.sh = {cmd_opcode_in, cmd_addr_in};
            endcase
            next_st.dq_o  = lanes(next_st.sh, cmd_quad_in);
            next_st.dq_oe = out_oe(cmd_quad_in);
          end
        end
      end
      qsf_pkg::qsf_st_gap: begin
        next_st.gap = st.gap + 4'h1;
        if (st.gap == GAP_LAST) begin
          next_st.state   = qsf_pkg::qsf_st_idle;
          next_st.cmd_rdy = 1'b1;
        end
      end
      default: begin
        next_st.div = tick ? '0 : st.div + 8'h01;
        if (tick && !st.sck) begin
          // hold clock low while the read fifo has no room
          if (!(st.state == qsf_pkg::qsf_st_rdata && st.bitc == '0 && !fifo_ready)) begin
            next_st.sck = 1'b1;
          end
        end else if (tick && (!need_byte || st.wbuf_full)) begin
          next_st.sck  = 1'b0;
          next_st.pos  = st.pos + 6'h01;
          next_st.bitc = st.bitc + 4'h1;
          case (st.state)
            qsf_pkg::qsf_st_shift: begin
              // RULE_04 register write length
              // RULE_07 extended cx
              // RULE_08 quad cx
              if (st.pos == st.last) begin
                next_st.bitc = '0;
                case (st.kind)
                  qsf_pkg::qsf_fast_rd: begin
                    next_st.state = qsf_pkg::qsf_st_dummy;
                    next_st.dq_oe = in_oe(st.quad);
                  end
                  qsf_pkg::qsf_page_prog: begin
                    next_st.state     = qsf_pkg::qsf_st_wdata;
                    next_st.sh        = {st.wbuf, 24'h000000};
                    next_st.wbuf_full = 1'b0;
                    next_st.wr_rdy    = 1'b1;
                    next_st.dq_o      = lanes(next_st.sh, st.quad);
                  end
                  qsf_pkg::qsf_reg_rd: begin
                    next_st.state = qsf_pkg::qsf_st_rdata;
                    next_st.dq_oe = in_oe(st.quad);
                  end
                  default: begin
                    next_st.state = qsf_pkg::qsf_st_gap;
                  end
                endcase
              end else begin
                next_st.sh   = st.sh << step(st.quad);
                next_st.dq_o = lanes(next_st.sh, st.quad);
              end
            end
            qsf_pkg::qsf_st_dummy: begin
              if (st.bitc == (st.quad ? `QSF_DUMMY_QUAD : `QSF_DUMMY_EXT) - 4'h1) begin
                next_st.bitc  = '0;
                next_st.state = qsf_pkg::qsf_st_rdata;
              end
            end
            qsf_pkg::qsf_st_rdata: begin
              // RULE_09 flash data sampled in
              // RULE_02 bytes kept in arrival order
              next_st.rx = st.quad ? {st.rx[3:0], st.sync2} : {st.rx[6:0], st.sync2[1]};
              if (byte_end) begin
                next_st.bitc = '0;
                next_st.push = 1'b1;
                next_st.len  = st.len - LEN_W'(1);
                if (st.len == LEN_W'(1)) begin
                  next_st.state = qsf_pkg::qsf_st_gap;
                end
              end
            end
            default: begin
              // RULE_10 page data driven out
              if (byte_end) begin
                next_st.bitc = '0;
                if (st.len == LEN_W'(1)) begin
                  next_st.state = qsf_pkg::qsf_st_gap;
                end else begin
                  next_st.len       = st.len - LEN_W'(1);
                  next_st.sh        = {st.wbuf, 24'h000000};
                  next_st.wbuf_full = 1'b0;
                  next_st.wr_rdy    = 1'b1;
                  next_st.dq_o      = lanes(next_st.sh, st.quad);
                end
              end else begin
                next_st.sh   = st.sh << step(st.quad);
                next_st.dq_o = lanes(next_st.sh, st.quad);
              end
            end
          endcase
          // RULE_11 deselect between frames
          if (next_st.state == qsf_pkg::qsf_st_gap) begin
            next_st.cs_n  = 1'b1;
            next_st.gap   = '0;
            next_st.done  = 1'b1;
            next_st.dq_o  = `QSF_OE_IDLE;
            next_st.dq_oe = `QSF_OE_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st         <= '0;
      st.state   <= qsf_pkg::qsf_st_idle;
      st.cs_n    <= 1'b1;
      st.cmd_rdy <= 1'b1;
      st.wr_rdy  <= 1'b1;
      st.dq_o    <= `QSF_OE_IDLE;
      st.dq_oe   <= `QSF_OE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  qsf_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (st.push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (st.rx),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );

  assign cmd_ready_out = st.cmd_rdy;
  assign cmd_done_out  = st.done;
  assign cmd_err_out   = st.err;
  assign wr_ready_out  = st.wr_rdy;
  assign sck_out       = st.sck;
  assign cs_n_out      = st.cs_n;
  assign dq_out        = st.dq_o;
  assign dq_oe_out     = st.dq_oe;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  lock_rd_refused_a: assert property ( // RULE_01
    (accept && cmd_kind_in == qsf_pkg::qsf_reg_rd && cmd_opcode_in == `QSF_LOCK_RD_OP)
    |=> cmd_err_out && cs_n_out && st.state == qsf_pkg::qsf_st_idle)
    else $error("lock register read was not refused");
  reg_rd_start_a: assert property ( // RULE_01
    (accept && cmd_kind_in == qsf_pkg::qsf_reg_rd && cmd_opcode_in != `QSF_LOCK_RD_OP)
    |=> !cs_n_out && !cmd_err_out)
    else $error("register read did not start");
  lock_wr_refused_a: assert property ( // RULE_03
    (accept && cmd_kind_in == qsf_pkg::qsf_reg_wr && cmd_opcode_in == `QSF_LOCK_WR_OP)
    |=> cmd_err_out && st.state == qsf_pkg::qsf_st_idle)
    else $error("lock register write was not refused");
  reg_wr_len_a: assert property ( // RULE_04
    ($rose(cs_n_out) && st.kind == qsf_pkg::qsf_reg_wr)
    |-> $past(st.pos) == (st.quad ? `QSF_RW_LAST_QUAD : `QSF_RW_LAST_EXT))
    else $error("register write frame has wrong length");
  reg_wr_lsb_a: assert property ( // RULE_05
    (accept && !lock_cmd && cmd_kind_in == qsf_pkg::qsf_reg_wr)
    |=> st.sh[23:16] == $past(cmd_reg_data_in[7:0]) && st.sh[15:8] == $past(cmd_reg_data_in[15:8]))
    else $error("register write data not low byte first");
  addr_msb_a: assert property ( // RULE_06
    (accept && cmd_kind_in == qsf_pkg::qsf_fast_rd)
    |=> st.sh[23:0] == $past(cmd_addr_in) && (st.quad || dq_out[0] == st.sh[31]))
    else $error("address not loaded msb first");
  cx_ext_a: assert property ( // RULE_07
    (st.state == qsf_pkg::qsf_st_shift && !st.quad && st.kind[1] &&
     next_st.state != qsf_pkg::qsf_st_shift) |-> st.pos == 6'd31)
    else $error("extended command and address phase not 31");
  cx_quad_a: assert property ( // RULE_08
    (st.state == qsf_pkg::qsf_st_shift && st.quad && st.kind[1] &&
     next_st.state != qsf_pkg::qsf_st_shift) |-> st.pos == 6'd7)
    else $error("quad command and address phase not 7");
  rd_released_a: assert property ( // RULE_09
    (st.state == qsf_pkg::qsf_st_rdata && st.quad) |-> dq_oe_out == 4'h0 && !cs_n_out)
    else $error("lanes driven during quad read data");
  pp_driven_a: assert property ( // RULE_10
    (st.state == qsf_pkg::qsf_st_wdata) |-> dq_oe_out == out_oe(st.quad) && !cs_n_out)
    else $error("page data not driven");
  cs_gap_a: assert property ( // RULE_11
    $rose(cs_n_out) |-> cs_n_out [*8] ##1 cs_n_out)
    else $error("chip select high time too short");

  fast_rd_quad_c: cover property (st.kind == qsf_pkg::qsf_fast_rd && st.quad && cmd_done_out);
  page_ext_c:     cover property (st.kind == qsf_pkg::qsf_page_prog && !st.quad && cmd_done_out);
  reg_wr_c:       cover property (st.kind == qsf_pkg::qsf_reg_wr && cmd_done_out);
  fifo_stall_c:   cover property (st.state == qsf_pkg::qsf_st_rdata && !fifo_ready && tick && !st.sck);
endmodule

//--- bench/qsf_flash_model.sv
// behavioural serial nor flash on the far side of the sequencer
// assumes mode 0 clocking; the bench tells it quad mode and when its data starts
`timescale 1ns/10ps
module qsf_flash_model (
  input  wire logic       core_clk_in,
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic [3:0] dq_dev_in,
  input  wire logic [3:0] dq_oe_in,
  input  wire logic       quad_in,
  input  wire logic [9:0] rd_start_in,
  output logic [3:0]      dq_pin_out
);
  logic [3:0] cap [0:1023];
  int         clks;
  int         frames;
  int         bp;
  logic       fdrv;
  logic [3:0] fv;
  logic       tog;
  logic [7:0] b;

  initial begin
    clks = 0;
    frames = 0;
    bp = 0;
    fdrv = 1'b0;
    fv = 4'h0;
    tog = 1'b0;
  end

  // undriven released lanes alternate between the last value and its inverse each clock
  always @(posedge core_clk_in) tog <= ~tog;
  always @(negedge cs_n_in) begin
    clks = 0;
    bp = 0;
    frames = frames + 1;
  end
  always @(posedge cs_n_in) fdrv = 1'b0;
  always @(posedge sck_in) begin
    if (!cs_n_in && clks < 1024) begin
      cap[clks] = dq_dev_in;
      clks = clks + 1;
    end
  end
  always @(negedge sck_in) begin
    if (!cs_n_in && clks >= rd_start_in) begin
      b = 8'ha5 + 8'(bp / 8);
      if (quad_in) begin
        fv = (bp % 8 == 0) ? b[7:4] : b[3:0];
        bp = bp + 4;
      end else begin
        fv = {2'h0, b[7 - bp % 8], 1'b0};
        bp = bp + 1;
      end
      fdrv = 1'b1;
    end
  end
  assign dq_pin_out = (dq_oe_in & dq_dev_in) | (~dq_oe_in & (fdrv ? fv : (~fv ^ {4{tog}})));
endmodule

//--- bench/test_quad_serial_flash_sequencer.sv
// self-checking bench of the quad serial flash sequencer
// assumes qsf_seq with default DIV, a flash model on the pins
`timescale 1ns/10ps
`include "qsf_defs.svh"
module test_quad_serial_flash_sequencer;
  typedef struct packed {
    qsf_pkg::qsf_kind_t kind;
    logic               quad;
    logic [7:0]         op;
    logic [23:0]        addr;
    logic [8:0]         len;
    logic [15:0]        rdat;
    logic [7:0]         nclk;
  } qsf_row_t;

  logic               core_clk_in;
  logic               rst_in;
  logic               cmd_valid_in;
  logic               cmd_ready_out;
  qsf_pkg::qsf_kind_t cmd_kind_in;
  logic               cmd_quad_in;
  logic [7:0]         cmd_opcode_in;
  logic [23:0]        cmd_addr_in;
  logic [8:0]         cmd_len_in;
  logic [15:0]        cmd_reg_data_in;
  logic               cmd_done_out;
  logic               cmd_err_out;
  logic               wr_valid_in;
  logic               wr_ready_out;
  logic [7:0]         wr_data_in;
  logic               rd_valid_out;
  logic               rd_ready_in;
  logic [7:0]         rd_data_out;
  logic               sck_out;
  logic               cs_n_out;
  logic [3:0]         dq_out;
  logic [3:0]         dq_oe_out;
  logic [3:0]         dq_in;
  logic               mquad;
  logic [9:0]         mstart;
  int                 wr_idx;
  int                 wr_lim;
  int                 nx;
  int                 wbase;
  logic               wr_stall;
  logic [7:0]         rxq [$];
  int                 bad_count;
  int                 tests_run;
  int                 f1;
  qsf_row_t           rows [8] = '{
    '{qsf_pkg::qsf_reg_rd,    1'b0, 8'h05, 24'h0,      9'h1, 16'h0,    8'h10},
    '{qsf_pkg::qsf_reg_rd,    1'b1, 8'hb5, 24'h0,      9'h2, 16'h0,    8'h06},
    '{qsf_pkg::qsf_reg_wr,    1'b0, 8'hb1, 24'h0,      9'h0, 16'h1234, 8'h18},
    '{qsf_pkg::qsf_reg_wr,    1'b1, 8'h01, 24'h0,      9'h0, 16'hbe9c, 8'h06},
    '{qsf_pkg::qsf_fast_rd,   1'b0, 8'h0b, 24'h81c3e7, 9'h3, 16'h0,    8'h40},
    '{qsf_pkg::qsf_fast_rd,   1'b1, 8'heb, 24'h5a0f96, 9'h2, 16'h0,    8'h16},
    '{qsf_pkg::qsf_page_prog, 1'b0, 8'h02, 24'hc0ffe1, 9'h2, 16'h0,    8'h30},
    '{qsf_pkg::qsf_page_prog, 1'b1, 8'h32, 24'h123456, 9'h3, 16'h0,    8'h0e}};

  qsf_seq #(.DIV(4), .LEN_W(9), .FIFO_DEPTH(16)) i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_kind_in(cmd_kind_in),
    .cmd_quad_in(cmd_quad_in), .cmd_opcode_in(cmd_opcode_in), .cmd_addr_in(cmd_addr_in),
    .cmd_len_in(cmd_len_in), .cmd_reg_data_in(cmd_reg_data_in), .cmd_done_out(cmd_done_out),
    .cmd_err_out(cmd_err_out), .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out),
    .wr_data_in(wr_data_in), .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
    .rd_data_out(rd_data_out), .sck_out(sck_out), .cs_n_out(cs_n_out), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out), .dq_in(dq_in));
  qsf_flash_model i_flash (.core_clk_in(core_clk_in), .sck_in(sck_out), .cs_n_in(cs_n_out),
    .dq_dev_in(dq_out), .dq_oe_in(dq_oe_out), .quad_in(mquad), .rd_start_in(mstart), .dq_pin_out(dq_in));

  always #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    if (rd_valid_out === 1'b1 && rd_ready_in) rxq.push_back(rd_data_out);
  end
  // page program bytes, held until taken
  always @(posedge core_clk_in) begin
    nx = (wr_valid_in && wr_ready_out === 1'b1) ? wr_idx + 1 : wr_idx;
    wr_idx <= nx;
    wr_data_in <= 8'h3c + 8'(nx);
    wr_valid_in <= (nx < wr_lim) && !wr_stall;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_done(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge core_clk_in);
      if (cmd_done_out === 1'b1) return;
    end
    bad_count++;
    $display("[ERR] %0t no end of command", $time);
    wrap_up();
  endtask
  task automatic issue(input qsf_row_t r);
    int n;
    n = (r.kind == qsf_pkg::qsf_reg_rd) ? 1 : 4;
    @(posedge core_clk_in);
    rxq.delete();
    wbase = wr_idx;
    if (r.kind == qsf_pkg::qsf_page_prog) wr_lim <= wr_idx + int'(r.len);
    mquad <= r.quad;
    mstart <= 10'(n * (r.quad ? 2 : 8) + ((r.kind == qsf_pkg::qsf_fast_rd) ?
              (r.quad ? `QSF_DUMMY_QUAD : `QSF_DUMMY_EXT) : 0));
    cmd_kind_in <= r.kind;
    cmd_quad_in <= r.quad;
    cmd_opcode_in <= r.op;
    cmd_addr_in <= r.addr;
    cmd_len_in <= r.len;
    cmd_reg_data_in <= r.rdat;
    cmd_valid_in <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge core_clk_in);
      if (cmd_ready_out === 1'b1) break;
    end
    if (cmd_ready_out !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t command not taken", $time);
      wrap_up();
    end
    cmd_valid_in <= 1'b0;
  endtask
  task automatic check_frame(input qsf_row_t r, input int f0);
    logic [7:0] s [32];
    logic [7:0] got;
    int         n;
    int         per;
    int         rx;
    per = r.quad ? 2 : 8;
    s[0] = r.op;
    n = 1;
    if (r.kind == qsf_pkg::qsf_reg_wr) begin
      s[1] = r.rdat[7:0];
      s[2] = r.rdat[15:8];
      n = 3;
    end
    if (r.kind[1]) begin
      s[1] = r.addr[23:16];
      s[2] = r.addr[15:8];
      s[3] = r.addr[7:0];
      n = 4;
    end
    if (r.kind == qsf_pkg::qsf_page_prog) begin
      for (int i = 0; i < int'(r.len); i++) s[n + i] = 8'h3c + 8'(wbase + i);
      n = n + int'(r.len);
    end
    rx = (r.kind == qsf_pkg::qsf_reg_rd || r.kind == qsf_pkg::qsf_fast_rd) ? int'(r.len) : 0;
    repeat (40) @(posedge core_clk_in);
    chk(i_flash.clks, r.nclk);
    chk(i_flash.frames - f0, 1);
    chk(cs_n_out, 1'b1);
    for (int k = 0; k < n; k++) begin
      if (r.quad) got = {i_flash.cap[2 * k], i_flash.cap[2 * k + 1]};
      else for (int j = 0; j < 8; j++) got[7 - j] = i_flash.cap[8 * k + j][0];
      chk(got, s[k]);
    end
    chk(rxq.size(), rx);
    for (int k = 0; k < rxq.size() && k < rx; k++) chk(rxq[k], 8'ha5 + 8'(k));
  endtask
  task automatic run(input qsf_row_t r);
    int f0;
    f0 = i_flash.frames;
    issue(r);
    wait_done(20000);
    check_frame(r, f0);
  endtask
  task automatic lock_try(input qsf_pkg::qsf_kind_t k, input logic [7:0] op);
    int   f0;
    logic seen;
    f0 = i_flash.frames;
    seen = 1'b0;
    issue('{k, 1'b0, op, 24'h0, 9'h1, 16'h0, 8'h00});
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      if (cmd_err_out === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1);
    chk(i_flash.frames - f0, 0);
  endtask
  task automatic idle_check;
    chk({cs_n_out, sck_out, dq_out, dq_oe_out, cmd_ready_out, wr_ready_out, cmd_done_out, cmd_err_out,
         rd_valid_out}, {1'b1, 1'b0, `QSF_OE_IDLE, `QSF_OE_IDLE, 2'h3, 3'h0});
  endtask

  initial begin
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    {cmd_valid_in, cmd_quad_in, cmd_opcode_in, cmd_addr_in, cmd_len_in, cmd_reg_data_in} = '0;
    cmd_kind_in = qsf_pkg::qsf_reg_rd;
    {wr_valid_in, wr_data_in, wr_stall, mquad, mstart} = '0;
    rd_ready_in = 1'b1;
    wr_idx = 0;
    wr_lim = 0;
    bad_count = 0;
    tests_run = 0;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    idle_check();
    foreach (rows[i]) run(rows[i]);
    lock_try(qsf_pkg::qsf_reg_rd, `QSF_LOCK_RD_OP);
    lock_try(qsf_pkg::qsf_reg_wr, `QSF_LOCK_WR_OP);
    // missing write byte pauses the link
    wr_stall <= 1'b1;
    f1 = i_flash.frames;
    issue(rows[6]);
    repeat (1000) @(posedge core_clk_in);
    chk({cs_n_out, sck_out}, 2'h1);
    wr_stall <= 1'b0;
    wait_done(20000);
    check_frame(rows[6], f1);
    // full receive buffer pauses the link
    rd_ready_in <= 1'b0;
    f1 = i_flash.frames;
    issue('{qsf_pkg::qsf_fast_rd, 1'b0, 8'h0b, 24'hfffffe, 9'h14, 16'h0, 8'hc8});
    repeat (3000) @(posedge core_clk_in);
    chk(cs_n_out, 1'b0);
    rd_ready_in <= 1'b1;
    wait_done(20000);
    check_frame('{qsf_pkg::qsf_fast_rd, 1'b0, 8'h0b, 24'hfffffe, 9'h14, 16'h0, 8'hc8}, f1);
    // reset in mid frame, then recovery
    issue(rows[4]);
    repeat (200) @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    idle_check();
    run(rows[5]);
    wrap_up();
  end
endmodule
